// >>> design/aux_sync_pkg.sv
// Offsets, field positions, reset values and state codes for the auxiliary sync outputs.
// Assumes a 32-bit plain register port and one pattern bit per clock cycle.
package aux_sync_pkg;

    // Register offsets (byte addresses)
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] DIV_OFS       = 8'h04;
    localparam logic [7:0] PAT_LEN_OFS   = 8'h08;
    localparam logic [7:0] SYNC_POS_OFS  = 8'h0C;
    localparam logic [7:0] MIXED_SEL_OFS = 8'h10;
    localparam logic [7:0] BST_DLY_OFS   = 8'h14;
    localparam logic [7:0] BST_WID_OFS   = 8'h18;
    localparam logic [7:0] STATUS_OFS    = 8'h1C;

    // Control field positions
    localparam int MODE_LSB    = 0;
    localparam int MERGE_BIT   = 2;
    localparam int GATE_EN_BIT = 3;

    // Auxiliary output selection codes
    localparam logic [1:0] SEL_OFF   = 2'h0;
    localparam logic [1:0] SEL_DIV   = 2'h1;
    localparam logic [1:0] SEL_SYNC  = 2'h2;
    localparam logic [1:0] SEL_BURST = 2'h3;

    // Divider limits and reset value
    localparam logic [9:0] DIV_MIN = 10'h004;
    localparam logic [9:0] DIV_MAX = 10'h200;
    localparam logic [9:0] DIV_RST = 10'h004;

    // Sync period alignment, single channel and merged channels
    localparam logic [36:0] MIN_LEN_1 = 37'h00_0000_0200;
    localparam logic [36:0] MIN_LEN_2 = 37'h00_0000_0400;
    localparam logic [36:0] ALIGN_1   = 37'h00_0000_007F;
    localparam logic [36:0] ALIGN_2   = 37'h00_0000_00FF;

    // Position and burst step shifts (8 bits or 16 bits)
    localparam int STEP_SH_1 = 3;
    localparam int STEP_SH_2 = 4;

    // Reset values
    localparam logic [31:0] PAT_LEN_RST = 32'h0000_0200;
    localparam logic [31:0] ZERO_RST    = 32'h0000_0000;

    // Burst marker states
    typedef enum logic [2:0] {
        B_IDLE  = 3'b001,
        B_DELAY = 3'b010,
        B_HIGH  = 3'b100
    } burst_state_t;

endpackage : aux_sync_pkg

// >>> design/half_period_div.sv
// Divided clock generator: toggles every N/2 input cycles.
// Assumes N is even and at least 4; restart pins the phase to a known point.
`timescale 1ns/100ps
module half_period_div #(
    parameter int NW = 10
) (
    // Clock and reset
    input  wire logic          mclk_i,
    input  wire logic          rst_i,
    // Control
    input  wire logic [NW-1:0] ratio_i,
    input  wire logic          restart_i,
    // Divided clock
    output logic               div_o
);

    // Below three bits the half count cannot hold the smallest ratio
    if (NW < 3) begin : g_nw_check
        $error("half_period_div: NW too small");
    end

    typedef struct packed {
        logic [NW-1:0] cnt;
        logic          lvl;
    } div_state_t;

    div_state_t cur_ff;
    div_state_t nxt_cur;
    logic [NW-1:0] half_m1;

    assign half_m1 = (ratio_i >> 1) - {{(NW-1){1'b0}}, 1'b1};

    always_comb begin
        nxt_cur = cur_ff;
        if (restart_i) begin
            // Phase locked to pattern start
            nxt_cur.cnt = half_m1;
            nxt_cur.lvl = 1'b1;
        end else if (cur_ff.cnt == '0) begin
            // 50 percent duty cycle
            nxt_cur.cnt = half_m1;
            nxt_cur.lvl = ~cur_ff.lvl;
        end else begin
            nxt_cur.cnt = cur_ff.cnt - {{(NW-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cur_ff <= '0;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    assign div_o = cur_ff.lvl;

endmodule : half_period_div

// >>> design/aux_sync_output_selector.sv
// Auxiliary timing outputs of a serial pattern generator: divided clock, pattern sync,
// burst marker or nothing on the aux pin, plus a switchable gate marker.
// Assumes one pattern bit per mclk_i cycle and pattern-engine strobes on the same clock.
//
// Contract
// RULE1: In divided-clock mode the aux output carries a clock that stays locked to the pattern.
// RULE2: The divide ratio N is programmable from 4 to 512 in steps of 2.
// RULE3: In pattern-sync mode exactly one pulse per pattern period appears on the aux output.
// RULE4: Single channel, the sync position runs from 1 up in 8-bit steps within lcm(len,128).
// RULE5: Merged channels, the sync position runs from 1 up in 16-bit steps within lcm(len,256).
// RULE6: A short pattern is extended to its least multiple of at least 512 (1024 merged) bits.
// RULE7: For the block-structured mixed pattern the pulse sits at a chosen block and row.
// RULE8: In burst sequence with burst marker selected the aux output mirrors the burst trigger.
// RULE9: The burst marker has a programmable delay and high width, both in bits.
// RULE10: Delay and width step by 8 bits on one channel and by 16 bits when merged.
// RULE11: With the aux selection off the aux pin is not driven.
// RULE12: The gate marker carries the sequence sync when enabled and nothing when disabled.
// RULE13: The divided clock toggles every N/2 bits with its phase fixed to pattern start.
//
// The register addresses and strobed register access are this design's own decisions.
`timescale 1ns/100ps
module aux_sync_output_selector (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wr_data_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rd_data_o,
    // Pattern engine strobes
    input  wire logic        pat_start_i,
    input  wire logic        mixed_pat_i,
    input  wire logic        row_start_i,
    input  wire logic [15:0] block_idx_i,
    input  wire logic [15:0] row_idx_i,
    // Burst sequencer strobes
    input  wire logic        burst_mode_i,
    input  wire logic        burst_start_i,
    input  wire logic        seq_sync_i,
    // Marker pins
    output logic             aux_o,
    output logic             aux_oe_o,
    output logic             gate_o,
    output logic             gate_oe_o
);
    import aux_sync_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic [1:0]   sel;
        logic         merge;
        logic         gate_en;
        logic [9:0]   ratio;
        logic [31:0]  pat_len;
        logic [31:0]  pos_step;
        logic [15:0]  sel_block;
        logic [15:0]  sel_row;
        logic [31:0]  dly_step;
        logic [31:0]  wid_step;
        logic [31:0]  bit_cnt;
        logic [36:0]  pos_cnt;
        // Bits since the stretched pattern last closed
        logic [36:0]  ext_cnt;
        burst_state_t bst;
        logic [36:0]  bst_cnt;
        logic         sync_hit;
        logic         aux;
        logic         aux_oe;
        logic         gate;
        logic         gate_oe;
        logic [31:0]  rdata;
    } sel_state_t;

    sel_state_t cur_ff;
    sel_state_t nxt_cur;

    logic        div_clk;
    logic        div_restart;
    logic [9:0]  wr_ratio;
    logic [36:0] pos_bits;
    logic [36:0] dly_bits;
    logic [36:0] wid_bits;
    logic [36:0] pos_inc;
    logic [36:0] min_len;
    logic [36:0] align;
    logic        pat_end;
    logic        period_end;
    logic        sync_lin;
    logic        sync_mix;
    logic [36:0] ext_inc;
    logic        ext_end;
    logic [31:0] ctrl_word;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////////////////
    // Divided clock

    // Restart on pattern start, and hold in restart while the aux selection is not the divided clock, so the edge pattern repeats with the data
    assign div_restart = pat_start_i | (cur_ff.sel != SEL_DIV);  // [RULE13]

    half_period_div #(
        .NW (10)
    ) u_div (
        .mclk_i    (mclk_i),
        .rst_i     (rst_i),
        .ratio_i   (cur_ff.ratio),
        .restart_i (div_restart),
        .div_o     (div_clk)
    );

    // Clamp to 4..512 and force even ratio
    always_comb begin
        wr_ratio = {wr_data_i[9:1], 1'b0};  // [RULE2]
        if (wr_data_i[31:10] != '0 || wr_ratio > DIV_MAX) begin
            wr_ratio = DIV_MAX;  // [RULE2]
        end else if (wr_ratio < DIV_MIN) begin
            wr_ratio = DIV_MIN;  // [RULE2]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Step scaling

    always_comb begin
        if (cur_ff.merge) begin
            pos_bits = {1'b0, cur_ff.pos_step, 4'h0};  // [RULE5]
            dly_bits = {1'b0, cur_ff.dly_step, 4'h0};  // [RULE10]
            wid_bits = {1'b0, cur_ff.wid_step, 4'h0};  // [RULE10]
            min_len  = MIN_LEN_2;  // [RULE6]
            align    = ALIGN_2;  // [RULE5]
        end else begin
            pos_bits = {2'h0, cur_ff.pos_step, 3'h0};  // [RULE4]
            dly_bits = {2'h0, cur_ff.dly_step, 3'h0};  // [RULE10]
            wid_bits = {2'h0, cur_ff.wid_step, 3'h0};  // [RULE10]
            min_len  = MIN_LEN_1;  // [RULE6]
            align    = ALIGN_1;  // [RULE4]
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Sync period tracking

    // A short pattern is stretched to whole repeats reaching the minimum length first
    assign pat_end    = (cur_ff.bit_cnt == cur_ff.pat_len - 32'h0000_0001);
    assign ext_inc    = cur_ff.ext_cnt + 37'h00_0000_0001;
    assign ext_end    = pat_end && (ext_inc >= min_len);  // [RULE6]

    // Sync period is the least multiple of the stretched length that is a multiple of 128 bits (256 merged)
    assign pos_inc    = cur_ff.pos_cnt + 37'h00_0000_0001;
    assign period_end = ext_end && ((pos_inc & align) == '0);  // [RULE4] [RULE5]

    // Position 1 is the first bit of the sync period
    assign sync_lin = (cur_ff.pos_cnt == pos_bits) && !mixed_pat_i;  // [RULE3]
    assign sync_mix = mixed_pat_i && row_start_i && (block_idx_i == cur_ff.sel_block)
                      && (row_idx_i == cur_ff.sel_row);  // [RULE7]

    ////////////////////////////////////////////////////////////////////////////////////
    // Read-back words

    // Built from the write positions so read-back and write stay in step
    always_comb begin
        ctrl_word                = 32'h0000_0000;
        ctrl_word[MODE_LSB +: 2] = cur_ff.sel;
        ctrl_word[MERGE_BIT]     = cur_ff.merge;
        ctrl_word[GATE_EN_BIT]   = cur_ff.gate_en;
    end

    always_comb begin
        status_word[31:7] = 25'h000_0000;
        status_word[6:4]  = cur_ff.bst;
        status_word[3]    = cur_ff.gate;
        status_word[2]    = cur_ff.aux_oe;
        status_word[1]    = cur_ff.aux;
        status_word[0]    = cur_ff.sync_hit;
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        nxt_cur = cur_ff;

        // Register writes
        if (wr_i) begin
            case (addr_i)
                CTRL_OFS: begin
                    nxt_cur.sel     = wr_data_i[MODE_LSB +: 2];
                    nxt_cur.merge   = wr_data_i[MERGE_BIT];
                    nxt_cur.gate_en = wr_data_i[GATE_EN_BIT];
                end
                DIV_OFS: begin
                    nxt_cur.ratio = wr_ratio;  // [RULE2]
                end
                PAT_LEN_OFS: begin
                    // Zero length would never close a period
                    nxt_cur.pat_len = (wr_data_i == '0) ? 32'h0000_0001 : wr_data_i;
                end
                SYNC_POS_OFS: begin
                    nxt_cur.pos_step = wr_data_i;  // [RULE4]
                end
                MIXED_SEL_OFS: begin
                    nxt_cur.sel_block = wr_data_i[31:16];  // [RULE7]
                    nxt_cur.sel_row   = wr_data_i[15:0];  // [RULE7]
                end
                BST_DLY_OFS: begin
                    nxt_cur.dly_step = wr_data_i;  // [RULE9]
                end
                BST_WID_OFS: begin
                    nxt_cur.wid_step = wr_data_i;  // [RULE9]
                end
                default: begin
                end
            endcase
        end

        // Register reads, data valid the following cycle
        nxt_cur.rdata = '0;
        if (rd_i) begin
            case (addr_i)
                CTRL_OFS:      nxt_cur.rdata = ctrl_word;
                DIV_OFS:       nxt_cur.rdata = {22'h00_0000, cur_ff.ratio};
                PAT_LEN_OFS:   nxt_cur.rdata = cur_ff.pat_len;
                SYNC_POS_OFS:  nxt_cur.rdata = cur_ff.pos_step;
                MIXED_SEL_OFS: nxt_cur.rdata = {cur_ff.sel_block, cur_ff.sel_row};
                BST_DLY_OFS:   nxt_cur.rdata = cur_ff.dly_step;
                BST_WID_OFS:   nxt_cur.rdata = cur_ff.wid_step;
                STATUS_OFS:    nxt_cur.rdata = status_word;
                default:       nxt_cur.rdata = '0;
            endcase
        end

        // Pattern position counters
        // A pattern start realigns all three to the first bit
        if (pat_start_i) begin
            nxt_cur.bit_cnt = '0;
            nxt_cur.pos_cnt = '0;
            nxt_cur.ext_cnt = '0;
        end else if (pat_end) begin
            nxt_cur.bit_cnt = '0;
            nxt_cur.pos_cnt = period_end ? '0 : pos_inc;  // [RULE6]
            nxt_cur.ext_cnt = ext_end ? '0 : ext_inc;  // [RULE6]
        end else begin
            nxt_cur.bit_cnt = cur_ff.bit_cnt + 32'h0000_0001;
            nxt_cur.pos_cnt = pos_inc;
            nxt_cur.ext_cnt = ext_inc;
        end

        // One pulse per sync period
        nxt_cur.sync_hit = sync_lin | sync_mix;  // [RULE3]

        // Burst marker: delay from burst start, then high for the width
        case (cur_ff.bst)
            B_IDLE: begin
                // Starts during delay or high are dropped so markers never overlap
                if (burst_start_i) begin
                    if (dly_bits != '0) begin
                        nxt_cur.bst     = B_DELAY;  // [RULE9]
                        nxt_cur.bst_cnt = dly_bits - 37'h00_0000_0001;
                    end else if (wid_bits != '0) begin
                        nxt_cur.bst     = B_HIGH;  // [RULE9]
                        nxt_cur.bst_cnt = wid_bits - 37'h00_0000_0001;
                    end
                end
            end
            B_DELAY: begin
                if (cur_ff.bst_cnt != '0) begin
                    nxt_cur.bst_cnt = cur_ff.bst_cnt - 37'h00_0000_0001;
                end else if (wid_bits != '0) begin
                    nxt_cur.bst     = B_HIGH;  // [RULE9]
                    nxt_cur.bst_cnt = wid_bits - 37'h00_0000_0001;
                end else begin
                    nxt_cur.bst = B_IDLE;
                end
            end
            B_HIGH: begin
                if (cur_ff.bst_cnt != '0) begin
                    nxt_cur.bst_cnt = cur_ff.bst_cnt - 37'h00_0000_0001;
                end else begin
                    nxt_cur.bst = B_IDLE;  // [RULE9]
                end
            end
            default: begin
                nxt_cur.bst     = B_IDLE;
                nxt_cur.bst_cnt = '0;
            end
        endcase

        // Aux pin selection
        case (cur_ff.sel)
            SEL_DIV: begin
                nxt_cur.aux    = div_clk;  // [RULE1]
                nxt_cur.aux_oe = 1'b1;
            end
            SEL_SYNC: begin
                nxt_cur.aux    = cur_ff.sync_hit;  // [RULE3]
                nxt_cur.aux_oe = 1'b1;
            end
            SEL_BURST: begin
                // Held low outside burst sequence
                nxt_cur.aux    = burst_mode_i && (cur_ff.bst == B_HIGH);  // [RULE8]
                nxt_cur.aux_oe = 1'b1;
            end
            default: begin
                nxt_cur.aux    = 1'b0;  // [RULE11]
                nxt_cur.aux_oe = 1'b0;  // [RULE11]
            end
        endcase

        // Gate marker
        // Enable and level register together so the pin never shows a stale level
        nxt_cur.gate    = cur_ff.gate_en & seq_sync_i;  // [RULE12]
        nxt_cur.gate_oe = cur_ff.gate_en;  // [RULE12]
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge mclk_i) begin
        if (rst_i) begin
            cur_ff           <= '0;
            cur_ff.ratio     <= DIV_RST;
            cur_ff.pat_len   <= PAT_LEN_RST;
            cur_ff.pos_step  <= ZERO_RST;
            cur_ff.dly_step  <= ZERO_RST;
            cur_ff.wid_step  <= ZERO_RST;
            cur_ff.bst       <= B_IDLE;
            cur_ff.sel       <= SEL_OFF;
        end else begin
            cur_ff <= nxt_cur;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rd_data_o = cur_ff.rdata;
    assign aux_o     = cur_ff.aux;
    assign aux_oe_o  = cur_ff.aux_oe;
    assign gate_o    = cur_ff.gate;
    assign gate_oe_o = cur_ff.gate_oe;

endmodule : aux_sync_output_selector

// >>> testbench/aux_sync_output_selector_props.sv
// Port-level checks of the aux and gate marker pins and the read port.
// Assumes only the top module's ports; bound at the foot of this file.
`timescale 1ns/100ps
module aux_sync_output_selector_props (
    // Clock and reset
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    // Register port
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    input  wire logic [31:0] rd_data_o,
    // Sequence sync and marker pins
    input  wire logic        seq_sync_i,
    input  wire logic        aux_o,
    input  wire logic        aux_oe_o,
    input  wire logic        gate_o,
    input  wire logic        gate_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    property p_gate_follow;
        gate_oe_o |-> gate_o == $past(seq_sync_i);
    endproperty
    a_gate_follow: assert property (p_gate_follow)
        else $error("gate marker lost the sequence sync");
    property p_gate_quiet;
        !gate_oe_o |-> !gate_o;
    endproperty
    a_gate_quiet: assert property (p_gate_quiet)
        else $error("gate marker high while not driven");
    property p_gate_run;
        (seq_sync_i && gate_oe_o) [*2] ##1 gate_oe_o |-> gate_o;
    endproperty
    a_gate_run: assert property (p_gate_run)
        else $error("gate marker missed a held sync");
    property p_aux_quiet;
        !aux_oe_o |-> !aux_o;
    endproperty
    a_aux_quiet: assert property (p_aux_quiet)
        else $error("aux high while not driven");
    property p_reset_idle;
        $fell(rst_i) |-> !aux_oe_o && !gate_oe_o && !aux_o && !gate_o;
    endproperty
    a_reset_idle: assert property (p_reset_idle)
        else $error("pins driven after reset");
    // Enables move only within three cycles after a register write to any address
    property p_aux_oe_cause;
        $changed(aux_oe_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
    endproperty
    a_aux_oe_cause: assert property (p_aux_oe_cause)
        else $error("aux enable changed without a write");
    property p_gate_oe_cause;
        $changed(gate_oe_o) |-> $past(wr_i) || $past(wr_i, 2) || $past(wr_i, 3);
    endproperty
    a_gate_oe_cause: assert property (p_gate_oe_cause)
        else $error("gate enable changed without a write");
    property p_rd_idle;
        !$past(rd_i) |-> rd_data_o == 32'h0000_0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("read data outside its cycle");
endmodule : aux_sync_output_selector_props

bind aux_sync_output_selector aux_sync_output_selector_props i_props (
    .mclk_i, .rst_i, .wr_i, .rd_i, .rd_data_o, .seq_sync_i,
    .aux_o, .aux_oe_o, .gate_o, .gate_oe_o);

// >>> testbench/aux_marker_monitor.sv
// Far-side instrument: counts aux pulses, last high width and rise spacing.
// Assumes the bit clock; an undriven pin reads low through its termination.
`timescale 1ns/100ps
module aux_marker_monitor (
    // Clock
    input  wire logic mclk_i,
    // Marker pin
    input  wire logic aux_i,
    input  wire logic aux_oe_i,
    // Measurements
    output int        pulses_o,
    output int        width_o,
    output int        period_o
);
    int   run_ff;
    int   since_ff;
    bit   lvl_ff;
    logic lvl;

    assign lvl = aux_oe_i & aux_i;

    always @(posedge mclk_i) begin
        lvl_ff <= lvl;
        since_ff <= since_ff + 1;
        if (lvl) begin
            run_ff <= run_ff + 1;
        end
        if (lvl && !lvl_ff) begin
            pulses_o <= pulses_o + 1;
            period_o <= since_ff;
            since_ff <= 1;
        end
        if (!lvl && lvl_ff) begin
            width_o <= run_ff;
            run_ff <= 0;
        end
    end
endmodule : aux_marker_monitor

// >>> testbench/aux_sync_output_selector_tb_top.sv
// Testbench top: register port tasks and marker scenarios.
// Assumes a 125 MHz bit clock and the far-side monitor beside the DUT.
`timescale 1ns/100ps
module aux_sync_output_selector_tb_top;
    import aux_sync_pkg::*;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  addr_i = 8'h00;
    logic [31:0] wr_data_i = 32'h0000_0000;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic        pat_start_i = 1'b0;
    logic        mixed_pat_i = 1'b0;
    logic        row_start_i = 1'b0;
    logic [15:0] block_idx_i = 16'h0000;
    logic [15:0] row_idx_i = 16'h0000;
    logic        burst_mode_i = 1'b0;
    logic        burst_start_i = 1'b0;
    logic        seq_sync_i = 1'b0;
    logic [31:0] rd_data_o;
    logic        aux_o, aux_oe_o, gate_o, gate_oe_o;
    int          fail_count = 0;
    int          checks = 0;
    int          pulses, width, period, d0, d1, p0;
    int          ratio [3] = '{4, 10, 512};
    int          slen [3] = '{512, 192, 192};
    int          sper [3] = '{512, 1152, 2304};
    logic        smrg [3] = '{1'b0, 1'b0, 1'b1};

    always #4 mclk_i = ~mclk_i;

    aux_sync_output_selector i_dut (.mclk_i, .rst_i, .addr_i, .wr_data_i, .wr_i, .rd_i,
        .rd_data_o, .pat_start_i, .mixed_pat_i, .row_start_i, .block_idx_i, .row_idx_i,
        .burst_mode_i, .burst_start_i, .seq_sync_i, .aux_o, .aux_oe_o, .gate_o, .gate_oe_o);
    aux_marker_monitor i_mon (.mclk_i, .aux_i(aux_o), .aux_oe_i(aux_oe_o),
        .pulses_o(pulses), .width_o(width), .period_o(period));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wr_data_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1;
        chk(rd_data_o, exp);
    endtask : rd
    task automatic kick(input bit burst);
        @(posedge mclk_i);
        pat_start_i <= !burst;
        burst_start_i <= burst;
        @(posedge mclk_i);
        pat_start_i <= 1'b0;
        burst_start_i <= 1'b0;
    endtask : kick
    // Bounded wait, so a missing pulse shows up as a wrong delay
    task automatic first_hit(output int n);
        #1;
        n = 0;
        while (aux_o !== 1'b1 && n < 4000) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
    endtask : first_hit
    task automatic settle(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask : settle
    task automatic end_sim;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #400000;
        fail_count++;
        end_sim();
    end

    initial begin
        repeat (5) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(CTRL_OFS, 32'h0000_0000);
        rd(PAT_LEN_OFS, 32'h0000_0200);
        rd(8'h20, 32'h0000_0000);
        rd(DIV_OFS, 32'h0000_0004);
        wr(DIV_OFS, 32'h0000_0005);
        rd(DIV_OFS, 32'h0000_0004);
        wr(DIV_OFS, 32'h0000_0258);
        rd(DIV_OFS, 32'h0000_0200);
        wr(DIV_OFS, 32'h0000_0002);
        rd(DIV_OFS, 32'h0000_0004);
        wr(CTRL_OFS, {30'h0, SEL_DIV});
        foreach (ratio[i]) begin
            wr(DIV_OFS, ratio[i]);
            kick(1'b0);
            settle(ratio[i] / 2);
            chk(aux_o, 1);
            settle(1);
            chk(aux_o, 0);
            settle(3 * ratio[i] + 8);
            chk(width, ratio[i] / 2);
            chk(period, ratio[i]);
        end
        foreach (slen[i]) begin
            wr(PAT_LEN_OFS, slen[i]);
            wr(CTRL_OFS, {29'h0, smrg[i], SEL_SYNC});
            wr(SYNC_POS_OFS, 32'h0000_0000);
            kick(1'b0);
            first_hit(d0);
            wr(SYNC_POS_OFS, 32'h0000_0002);
            kick(1'b0);
            first_hit(d1);
            chk(d1 - d0, smrg[i] ? 32 : 16);
            settle(2 * sper[i] + 8);
            chk(period, sper[i]);
            chk(width, 1);
            chk(aux_oe_o, 1);
        end
        // Mixed pattern: only the chosen block and row fires
        @(posedge mclk_i);
        mixed_pat_i <= 1'b1;
        wr(MIXED_SEL_OFS, 32'h0001_0002);
        wr(CTRL_OFS, {30'h0, SEL_SYNC});
        settle(4);
        p0 = pulses;
        for (int b = 0; b < 3; b++) begin
            for (int r = 0; r < 4; r++) begin
                @(posedge mclk_i);
                block_idx_i <= 16'(b);
                row_idx_i <= 16'(r);
                row_start_i <= 1'b1;
                @(posedge mclk_i);
                row_start_i <= 1'b0;
                settle(4);
            end
        end
        chk(pulses - p0, 1);
        @(posedge mclk_i);
        mixed_pat_i <= 1'b0;
        burst_mode_i <= 1'b1;
        wr(BST_WID_OFS, 32'h0000_0003);
        for (int m = 0; m < 2; m++) begin
            wr(CTRL_OFS, {29'h0, m[0], SEL_BURST});
            wr(BST_DLY_OFS, 32'h0000_0000);
            kick(1'b1);
            first_hit(d0);
            settle(60);
            wr(BST_DLY_OFS, 32'h0000_0002);
            kick(1'b1);
            first_hit(d1);
            chk(d1 - d0, 16 << m);
            settle(60);
            chk(width, 24 << m);
        end
        wr(BST_WID_OFS, 32'h0000_0000);
        p0 = pulses;
        kick(1'b1);
        settle(60);
        wr(BST_WID_OFS, 32'h0000_0003);
        burst_mode_i <= 1'b0;
        kick(1'b1);
        settle(80);
        chk(pulses - p0, 0);
        // Aux off, gate marker on, then off
        wr(CTRL_OFS, 32'h0000_0008);
        seq_sync_i <= 1'b1;
        settle(4);
        chk(aux_oe_o, 0);
        chk({gate_oe_o, gate_o}, 3);
        @(posedge mclk_i);
        seq_sync_i <= 1'b0;
        settle(2);
        chk({gate_oe_o, gate_o}, 2);
        wr(CTRL_OFS, 32'h0000_0000);
        seq_sync_i <= 1'b1;
        settle(4);
        chk({gate_oe_o, gate_o}, 0);
        // Reset in mid-run drops every pin and the control word
        wr(CTRL_OFS, 32'h0000_0009);
        settle(4);
        @(posedge mclk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge mclk_i);
        rst_i <= 1'b0;
        rd(CTRL_OFS, 32'h0000_0000);
        chk({aux_oe_o, gate_oe_o}, 0);
        end_sim();
    end
endmodule : aux_sync_output_selector_tb_top
